// ===== rtl/pack_extend_pkg.sv
/*
  shared types and constants for the pack and extend datapath slice.
  assumes a 32-bit word and a decode stage that supplies one operation per cycle.
*/
`default_nettype none
package pack_extend_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned HALF_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned SHIFT_W     = 5;
  localparam int unsigned REG_IDX_W   = 4;
  localparam logic [1:0]  ROT_0       = 2'h0;
  localparam logic [1:0]  ROT_8       = 2'h1;
  localparam logic [1:0]  ROT_16      = 2'h2;
  localparam logic [1:0]  ROT_24      = 2'h3;
  localparam logic [5:0]  ASR_FULL    = 6'h20;
  localparam logic [3:0]  SP_INDEX    = 4'hD;
  localparam logic [3:0]  PC_INDEX    = 4'hF;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [3:0]  IDX_ZERO    = 4'h0;

  typedef enum logic [3:0] {
    pack_low_high,
    pack_high_low,
    signed_byte_extend,
    signed_half_extend,
    dual_signed_byte_extend,
    unsigned_byte_extend,
    unsigned_half_extend,
    dual_unsigned_byte_extend,
    signed_byte_extend_add,
    signed_half_extend_add,
    dual_signed_byte_extend_add,
    unsigned_byte_extend_add,
    unsigned_half_extend_add,
    dual_unsigned_byte_extend_add
  } op_t;

  typedef struct packed {
    logic        valid;
    op_t         op;
    logic [31:0] first_operand_register;
    logic [31:0] second_operand_register;
    logic [4:0]  shift_amount;
    logic [1:0]  rotate_sel;
    logic [3:0]  dest_index;
    logic [3:0]  flags;
  } issue_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [3:0]  dest_index;
    logic [3:0]  flags;
  } result_t;
endpackage
`default_nettype wire

// ===== rtl/halfword_packer.sv
/*
  combinational halfword pack: low-high with left shift, high-low with arithmetic right shift.
  assumes operands settle within one core clock period.
*/
`default_nettype none
module halfword_packer
  import pack_extend_pkg::*;
(
  input  wire logic              high_low,
  input  wire logic [WORD_W-1:0] first_word,
  input  wire logic [WORD_W-1:0] second_word,
  input  wire logic [SHIFT_W-1:0] shift_amount,
  output logic      [WORD_W-1:0] packed_word
);
  logic [WORD_W-1:0] shifted_left;
  logic [WORD_W-1:0] shifted_right;
  logic [5:0]        asr_amount;

  always_comb
  begin
    shifted_left  = second_word << shift_amount;
    asr_amount    = (shift_amount == 5'h00) ? ASR_FULL : {1'b0, shift_amount};
    shifted_right = WORD_W'($signed(second_word) >>> asr_amount);
    if (high_low)
    begin
      packed_word = {first_word[31:16], shifted_right[15:0]};
    end
    else
    begin
      packed_word = {shifted_left[31:16], first_word[15:0]};
    end
  end
endmodule
`default_nettype wire

// ===== rtl/rotate_extender.sv
/*
  combinational rotate-right then byte or halfword extraction with sign or zero fill.
  assumes rotate select is one of 0, 8, 16 or 24 bits.
*/
`default_nettype none
module rotate_extender
  import pack_extend_pkg::*;
(
  input  wire logic [WORD_W-1:0] source_word,
  input  wire logic [1:0]        rotate_sel,
  input  wire logic              sign_fill,
  input  wire logic              half_size,
  input  wire logic              dual_lane,
  output logic      [WORD_W-1:0] extended_word
);
  logic [WORD_W-1:0] rotated;

  always_comb
  begin
    case (rotate_sel)
      ROT_8:   rotated = {source_word[7:0], source_word[31:8]};
      ROT_16:  rotated = {source_word[15:0], source_word[31:16]};
      ROT_24:  rotated = {source_word[23:0], source_word[31:24]};
      default: rotated = source_word;
    endcase
    if (dual_lane)
    begin
      extended_word = {{8{sign_fill & rotated[23]}}, rotated[23:16],
                       {8{sign_fill & rotated[7]}}, rotated[7:0]};
    end
    else if (half_size)
    begin
      extended_word = {{16{sign_fill & rotated[15]}}, rotated[15:0]};
    end
    else
    begin
      extended_word = {{24{sign_fill & rotated[7]}}, rotated[7:0]};
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pack_extend_datapath.sv
/*
  execute-stage slice for pack, extend and extend-add operations, one registered result stage.
  assumes decode supplies a valid operation each cycle it wants one and keeps sp and pc
  off the destination of a pack.
*/
// How it works
// - low-high pack keeps first operand low half
// - low-high pack takes shifted second upper half
// - high-low pack keeps first operand high half
// - high-low pack takes shifted second lower half
// - left shift 1..31, zero means none
// - arithmetic right 1..32, zero encodes 32
// - packs leave flags unchanged
// - extends rotate source right 0/8/16/24
// - no rotation selected uses source unrotated
// - signed byte extend replicates bit seven
// - unsigned byte extend fills zeros above
// - halfword extends sign or zero fill
// - dual signed byte extend into lanes
// - dual unsigned byte extend into lanes
// - extend-add sums word or lanes
// - extends and adds leave flags unchanged
`default_nettype none
module pack_extend_datapath
  import pack_extend_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    reset,
  input  wire issue_t  issue,
  output result_t      result
);
  typedef struct packed {
    result_t res;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic [WORD_W-1:0] packed_word;
  logic [WORD_W-1:0] extended_word;
  logic              is_pack;
  logic              is_add;
  logic              is_dual;
  logic              is_half;
  logic              is_signed;

  function automatic logic [WORD_W-1:0] lane_add(input logic [WORD_W-1:0] a,
                                                 input logic [WORD_W-1:0] b,
                                                 input logic              dual);
    logic [WORD_W-1:0] sum;
    sum = WORD_ZERO;
    if (dual)
    begin
      sum = {16'(a[31:16] + b[31:16]), 16'(a[15:0] + b[15:0])};
    end
    else
    begin
      sum = 32'(a + b);
    end
    return sum;
  endfunction

  always_comb
  begin
    is_pack   = (issue.op == pack_low_high) || (issue.op == pack_high_low);
    is_add    = (issue.op == signed_byte_extend_add) || (issue.op == signed_half_extend_add)
             || (issue.op == dual_signed_byte_extend_add)
             || (issue.op == unsigned_byte_extend_add) || (issue.op == unsigned_half_extend_add)
             || (issue.op == dual_unsigned_byte_extend_add);
    is_dual   = (issue.op == dual_signed_byte_extend) || (issue.op == dual_unsigned_byte_extend)
             || (issue.op == dual_signed_byte_extend_add)
             || (issue.op == dual_unsigned_byte_extend_add);
    is_half   = (issue.op == signed_half_extend) || (issue.op == unsigned_half_extend)
             || (issue.op == signed_half_extend_add) || (issue.op == unsigned_half_extend_add);
    is_signed = (issue.op == signed_byte_extend) || (issue.op == signed_half_extend)
             || (issue.op == dual_signed_byte_extend) || (issue.op == signed_byte_extend_add)
             || (issue.op == signed_half_extend_add)
             || (issue.op == dual_signed_byte_extend_add);
  end

  halfword_packer packer_i (
    .high_low     (issue.op == pack_high_low),
    .first_word   (issue.first_operand_register),
    .second_word  (issue.second_operand_register),
    .shift_amount (issue.shift_amount),
    .packed_word  (packed_word)
  );

  rotate_extender extender_i (
    .source_word   (is_pack ? WORD_ZERO : (is_add ? issue.second_operand_register
                                                  : issue.first_operand_register)),
    .rotate_sel    (issue.rotate_sel),
    .sign_fill     (is_signed),
    .half_size     (is_half),
    .dual_lane     (is_dual),
    .extended_word (extended_word)
  );

  always_comb
  begin
    state_d                = state_q;
    state_d.res.valid      = issue.valid;
    state_d.res.dest_index = issue.dest_index;
    state_d.res.flags      = issue.flags;
    if (is_pack)
    begin
      state_d.res.data = packed_word;
    end
    else if (is_add)
    begin
      state_d.res.data = lane_add(issue.first_operand_register, extended_word, is_dual);
    end
    else
    begin
      state_d.res.data = extended_word;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_q.res.valid      <= 1'b0;
      state_q.res.data       <= WORD_ZERO;
      state_q.res.dest_index <= IDX_ZERO;
      state_q.res.flags      <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign result = state_q.res;

  logic [WORD_W-1:0] exp_low_high;
  logic [WORD_W-1:0] exp_high_low;
  always_comb
  begin
    exp_low_high = issue.second_operand_register << issue.shift_amount;
    exp_high_low = WORD_W'($signed(issue.second_operand_register) >>>
                   ((issue.shift_amount == 5'h00) ? ASR_FULL : {1'b0, issue.shift_amount}));
  end

  sequence pack_lh_s;
    issue.valid && issue.op == pack_low_high;
  endsequence

  sequence pack_hl_s;
    issue.valid && issue.op == pack_high_low;
  endsequence

  low_half_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_lh_s |=> result.data[15:0] == $past(issue.first_operand_register[15:0]))
    else $error("low-high pack lost first operand low half");
  high_from_shift_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_lh_s |=> result.data[31:16] == $past(exp_low_high[31:16]))
    else $error("low-high pack upper half wrong");
  high_half_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_hl_s |=> result.data[31:16] == $past(issue.first_operand_register[31:16]))
    else $error("high-low pack lost first operand high half");
  low_from_asr_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_hl_s |=> result.data[15:0] == $past(exp_high_low[15:0]))
    else $error("high-low pack lower half wrong");
  asr_full_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_hl_s ##0 (issue.shift_amount == 5'h00) |=>
      result.data[15:0] == {16{$past(issue.second_operand_register[31])}})
    else $error("zero shift field not treated as 32");
  zero_shift_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_lh_s ##0 (issue.shift_amount == 5'h00) |=>
      result.data[31:16] == $past(issue.second_operand_register[31:16]))
    else $error("zero shift did not pass upper half");
  flags_kept_a: assert property (@(posedge sys_clk) disable iff (reset)
    issue.valid |=> result.flags == $past(issue.flags) && result.valid)
    else $error("flags changed by pack or extend");
  sbyte_ext_a: assert property (@(posedge sys_clk) disable iff (reset)
    issue.valid && issue.op == signed_byte_extend && issue.rotate_sel == ROT_0 |=>
      result.data == {{24{$past(issue.first_operand_register[7])}},
                      $past(issue.first_operand_register[7:0])})
    else $error("signed byte extend wrong");
  dual_add_a: assert property (@(posedge sys_clk) disable iff (reset)
    issue.valid && issue.op == dual_unsigned_byte_extend_add && issue.rotate_sel == ROT_0 |=>
      result.data[15:0] == 16'($past(issue.first_operand_register[15:0])
                               + $past({8'h00, issue.second_operand_register[7:0]})))
    else $error("dual lane add carried or misplaced");

  // the slices below assume a 32-bit word split in halves and bytes
  if (WORD_W != 32 || HALF_W != 16 || BYTE_W != 8)
  begin : g_width_check
    $error("datapath slices assume a 32-bit word");
  end

  // reference values for the checks, built by wide shifts and casts
  logic [4:0]          ref_rot_amt;
  logic [2*WORD_W-1:0] ref_twice;
  logic [WORD_W-1:0]   ref_src;
  logic [WORD_W-1:0]   ref_rot;
  logic [HALF_W-1:0]   ref_lane_lo;
  logic [HALF_W-1:0]   ref_lane_hi;
  logic [WORD_W-1:0]   ref_half;
  logic [WORD_W-1:0]   ref_byte;
  logic [WORD_W-1:0]   ref_ext;
  logic [2*WORD_W-1:0] ref_asr_wide;
  logic [2*WORD_W-1:0] ref_shl_wide;

  always_comb
  begin
    ref_src      = is_add ? issue.second_operand_register : issue.first_operand_register;
    ref_rot_amt  = {issue.rotate_sel, 3'h0};
    ref_twice    = {ref_src, ref_src} >> ref_rot_amt;
    ref_rot      = ref_twice[WORD_W-1:0];
    ref_lane_lo  = is_signed ? 16'($signed(ref_rot[7:0])) : 16'(ref_rot[7:0]);
    ref_lane_hi  = is_signed ? 16'($signed(ref_rot[23:16])) : 16'(ref_rot[23:16]);
    ref_half     = is_signed ? 32'($signed(ref_rot[15:0])) : 32'(ref_rot[15:0]);
    ref_byte     = is_signed ? 32'($signed(ref_rot[7:0])) : 32'(ref_rot[7:0]);
    ref_ext      = is_dual ? {ref_lane_hi, ref_lane_lo} : (is_half ? ref_half : ref_byte);
    ref_asr_wide = {{WORD_W{issue.second_operand_register[31]}},
                    issue.second_operand_register}
                   >> ((issue.shift_amount == 5'h00) ? ASR_FULL : {1'b0, issue.shift_amount});
    ref_shl_wide = {WORD_ZERO, issue.second_operand_register} << issue.shift_amount;
  end

  sequence ext_only_s;
    issue.valid && !is_pack && !is_add;
  endsequence

  sequence ext_add_s;
    issue.valid && is_add;
  endsequence

  sequence ubyte_s;
    issue.valid && issue.op == unsigned_byte_extend;
  endsequence

  sequence dual_signed_s;
    issue.valid && issue.op == dual_signed_byte_extend;
  endsequence

  sequence dual_zero_s;
    issue.valid && issue.op == dual_unsigned_byte_extend;
  endsequence

  sequence pack_any_s;
    issue.valid && is_pack;
  endsequence

  rot_extend_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_only_s ##0 (issue.rotate_sel != ROT_0) |=>
      result.data == $past(ref_ext))
    else $error("rotated extend wrong");

  no_rot_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_only_s ##0 (issue.rotate_sel == ROT_0) |=>
      result.data == $past(ref_ext))
    else $error("unrotated extend wrong");

  sbyte_rot_a: assert property (@(posedge sys_clk) disable iff (reset)
    issue.valid && issue.op == signed_byte_extend |=>
      result.data == $past(ref_byte))
    else $error("signed byte extend after rotate wrong");

  ubyte_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    ubyte_s |=>
      result.data == {24'h00_0000, $past(ref_rot[7:0])})
    else $error("unsigned byte extend not zero filled");

  half_fill_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_only_s ##0 is_half |=>
      result.data[31:16] == {16{$past(is_signed) && result.data[15]}})
    else $error("halfword extend fill wrong");

  half_value_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_only_s ##0 is_half |=>
      result.data == $past(ref_half))
    else $error("halfword extend value wrong");

  dual_sign_a: assert property (@(posedge sys_clk) disable iff (reset)
    dual_signed_s |=>
      result.data[15:8] == {8{result.data[7]}} && result.data[31:24] == {8{result.data[23]}})
    else $error("dual signed extend lanes wrong");

  dual_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    dual_zero_s |=>
      result.data[15:8] == 8'h00 && result.data[31:24] == 8'h00)
    else $error("dual unsigned extend lanes not zero filled");

  word_add_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_add_s ##0 !is_dual |=>
      result.data == 32'($past(issue.first_operand_register) + $past(ref_ext)))
    else $error("word extend add wrong");

  lane_low_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_add_s ##0 is_dual |=>
      result.data[15:0] == 16'($past(issue.first_operand_register[15:0]) + $past(ref_lane_lo)))
    else $error("dual add low lane wrong");

  lane_high_a: assert property (@(posedge sys_clk) disable iff (reset)
    ext_add_s ##0 is_dual |=>
      result.data[31:16] == 16'($past(issue.first_operand_register[31:16]) + $past(ref_lane_hi)))
    else $error("dual add high lane carried or misplaced");

  shift_left_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_lh_s |=>
      result.data[31:16] == $past(ref_shl_wide[31:16]))
    else $error("low-high pack shift wrong");

  asr_range_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_hl_s |=>
      result.data[15:0] == $past(ref_asr_wide[15:0]))
    else $error("high-low pack arithmetic shift wrong");

  pack_flags_a: assert property (@(posedge sys_clk) disable iff (reset)
    pack_any_s |=>
      result.flags == $past(issue.flags))
    else $error("pack changed the flags");

  ext_flags_a: assert property (@(posedge sys_clk) disable iff (reset)
    issue.valid && !is_pack |=>
      result.flags == $past(issue.flags))
    else $error("extend or add changed the flags");

  dest_pass_a: assert property (@(posedge sys_clk) disable iff (reset)
    issue.valid |=>
      result.dest_index == $past(issue.dest_index))
    else $error("destination index not carried");
endmodule
`default_nettype wire

// ===== verification/decode_model.sv
/*
  partner model: decode stage and register file in front of the datapath issue port.
  assumes the bench presents one request per core clock, changed just after the edge.
*/
`default_nettype none
module decode_model
  import pack_extend_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire issue_t req,
  output var  issue_t issue
);
  logic [63:0] last_q;

  // idle cycles show inverted operands, not the last ones
  always_ff @(posedge sys_clk)
  begin
    if (req.valid)
      last_q <= {req.first_operand_register, req.second_operand_register};
  end

  always_comb
  begin
    issue = req;
    if (!req.valid)
      {issue.first_operand_register, issue.second_operand_register} = ~last_q;
    if (req.op inside {pack_low_high, pack_high_low} &&
        req.dest_index inside {SP_INDEX, PC_INDEX})
      issue.dest_index = IDX_ZERO;
  end
endmodule
`default_nettype wire

// ===== verification/tb_pack_extend_datapath.sv
/*
  self-checking bench for the pack and extend datapath slice.
  assumes a one-cycle registered result and the decode partner model in front.
*/
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb_pack_extend_datapath
  import pack_extend_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk    = 1'b0;
  logic        reset;
  issue_t      req;
  issue_t      issue;
  result_t     result;
  issue_t      seen_q;
  logic        seen_rst_q = 1'b1;
  int          err_count;
  int          samples_checked;
  logic [31:0] corner [4] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h8080_8080, 32'h7F7F_FF7F};
  logic [4:0]  shifts [4] = '{5'h00, 5'h01, 5'h10, 5'h1F};

  decode_model i_partner (.sys_clk(sys_clk), .req(req), .issue(issue));
  pack_extend_datapath i_dut (.sys_clk(sys_clk), .reset(reset), .issue(issue), .result(result));

  function automatic logic [31:0] expect_data(issue_t i);
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [31:0] e;
    logic [63:0] w;
    a = i.first_operand_register;
    b = i.second_operand_register;
    if (i.op == pack_low_high)
    begin
      w = {32'h0000_0000, b} << i.shift_amount;
      return {w[31:16], a[15:0]};
    end
    if (i.op == pack_high_low)
    begin
      w = {{32{b[31]}}, b} >> ((i.shift_amount == 5'h00) ? 32 : i.shift_amount);
      return {a[31:16], w[15:0]};
    end
    w = (i.op >= signed_byte_extend_add) ? {b, b} : {a, a};
    w = w >> (8 * i.rotate_sel);
    r = w[31:0];
    case (i.op)
      signed_byte_extend, signed_byte_extend_add: e = {{24{r[7]}}, r[7:0]};
      unsigned_byte_extend, unsigned_byte_extend_add: e = {24'h00_0000, r[7:0]};
      signed_half_extend, signed_half_extend_add: e = {{16{r[15]}}, r[15:0]};
      unsigned_half_extend, unsigned_half_extend_add: e = {16'h0000, r[15:0]};
      dual_signed_byte_extend, dual_signed_byte_extend_add:
        e = {{8{r[23]}}, r[23:16], {8{r[7]}}, r[7:0]};
      default: e = {8'h00, r[23:16], 8'h00, r[7:0]};
    endcase
    if (i.op < signed_byte_extend_add)
      return e;
    if (i.op inside {dual_signed_byte_extend_add, dual_unsigned_byte_extend_add})
      return {a[31:16] + e[31:16], a[15:0] + e[15:0]};
    return a + e;
  endfunction

  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic send(input op_t op, input logic [4:0] sh, input logic [1:0] rot,
                      input logic [31:0] b, input logic v);
    @(posedge sys_clk);
    req <= '{v, op, $urandom, b, sh, rot, 4'($urandom), 4'($urandom)};
  endtask

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  // capture what the edge sampled, compare once the result has settled
  always @(posedge sys_clk)
  begin
    seen_q = issue;
    seen_rst_q = reset;
  end

  always @(negedge sys_clk)
  begin
    if (seen_rst_q)
      `CHK(result, '0)
    else if (seen_q.valid === 1'b1)
    begin
      `CHK(result.valid, 1'b1)
      `CHK(result.data, expect_data(seen_q))
      `CHK(result.dest_index, seen_q.dest_index)
      `CHK(result.flags, seen_q.flags)
    end
    else
      `CHK(result.valid, 1'b0)
  end

  initial
  begin
    req = '0;
    reset = 1'b1;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(32'h58E7F989));
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    // every op with every rotation, each shift boundary paired with one second-operand sign pattern
    for (int o = 0; o < 14; o++)
      for (int k = 0; k < 16; k++)
        send(op_t'(o), shifts[k % 4], 2'(k / 4), corner[k % 4], 1'b1);
    for (int n = 0; n < 400; n++)
    begin
      send(op_t'($urandom_range(13)), 5'($urandom), 2'($urandom), $urandom, 1'($urandom));
      if (n == 200)
      begin
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
      end
    end
    repeat (2) @(posedge sys_clk);
    end_sim();
  end

  initial
  begin
    repeat (2000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
